/* src/pwr_down_map.svh */
`ifndef PWR_DOWN_MAP_SVH
`define PWR_DOWN_MAP_SVH

// power control register bit holding the power-down request
`define PWR_CTRL_REQ_BIT 1
// program fetch address after the internal reset takes over
`define RESET_VECTOR 16'h0000
// count loaded on a reset wake-up; the core runs one cycle more than this before reset takes control
`define RESET_TAKEOVER_CYC 4'h8
// oscillator start-up cycles counted after an interrupt wake-up
`define OSC_START_CYC 4'h4

`endif

/* src/pwr_down_pkg.sv */
package pwr_down_pkg;

  // sequencer states, gray coded along run -> down -> interrupt wake -> run
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_DOWN = 3'b001,
    ST_OSC = 3'b011,
    ST_HOLD = 3'b010,
    ST_RSTWIN = 3'b110,
    ST_RSTSEQ = 3'b111
  } pd_state_type;

endpackage

/* src/power_down_mode_control.sv */
`include "pwr_down_map.svh"
// Function
// RULE1: power-down starts once request instruction executes
// RULE2: core halts after the request instruction
// RULE3: internal RAM kept unchanged in power-down
// RULE4: enabled external interrupt ends power-down
// RULE5: interrupt wake clears request, restarts clocks
// RULE6: core waits until waking interrupt released
// RULE7: service routine runs, then next instruction
// RULE8: software sets wake interrupt level-sensitive
// RULE9: software gives wake interrupt top priority
// RULE10: source holds interrupt until oscillator stable
// RULE11: interrupt wake keeps registers and RAM
// RULE12: high reset clears request asynchronously
// RULE13: core may run briefly before reset takes over
// RULE14: reset initialises and fetches from 0000h
// RULE15: RAM blocked, ports open in that window
// RULE16: software avoids port writes after entry
// RULE17: reset wake restores registers, keeps RAM
// RULE18: reset and idle pin states as tabled
// RULE19: power-down pin states as tabled
// RULE20: oscillator and clocks stopped in power-down
module power_down_mode_control (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic RST_PIN_I,
  input wire logic PD_SET_I,
  input wire logic IDLE_I,
  input wire logic EXT_CODE_I,
  input wire logic EXT_IRQ_ZERO_N_I,
  input wire logic EXT_IRQ_ONE_N_I,
  input wire logic IRQ_ZERO_EN_I,
  input wire logic IRQ_ONE_EN_I,
  output logic POWER_DOWN_REQUEST_BIT_O,
  output logic OSC_EN_O,
  output logic CLK_GATE_EN_O,
  output logic CORE_RUN_O,
  output logic IRQ_SERVICE_O,
  output logic RAM_ACCESS_EN_O,
  output logic SFR_RESET_O,
  output logic [15:0] FETCH_VECTOR_O,
  output logic FETCH_LOAD_O,
  output logic PORT0_OE_N_O,
  output logic PORTS_FORCE_HIGH_O,
  output logic ALE_O,
  output logic PROGRAM_STORE_STROBE_N_O
);

  pwr_down_pkg::pd_state_type state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic wake_src_q, wake_src_d; // 0: irq zero, 1: irq one
  logic pd_bit_q, pd_bit_d;
  logic rst_pin_q, rst_pin_d;
  logic wake_zero, wake_one, waking_level;

  // only enabled inputs count as wake-up; low level is active
  assign wake_zero = IRQ_ZERO_EN_I && !EXT_IRQ_ZERO_N_I; // RULE4
  assign wake_one = IRQ_ONE_EN_I && !EXT_IRQ_ONE_N_I; // RULE4
  assign waking_level = wake_src_q ? wake_one : wake_zero;

  // next-state logic of the sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    wake_src_d = wake_src_q;
    pd_bit_d = pd_bit_q;
    rst_pin_d = RST_PIN_I;
    unique case (state_q)
      pwr_down_pkg::ST_RUN: begin
        if (PD_SET_I) begin
          pd_bit_d = 1'b1; // RULE1
          state_d = pwr_down_pkg::ST_DOWN; // RULE1
        end
      end
      pwr_down_pkg::ST_DOWN: begin
        if (wake_zero || wake_one) begin
          pd_bit_d = 1'b0; // RULE5
          wake_src_d = !wake_zero;
          cnt_d = `OSC_START_CYC;
          state_d = pwr_down_pkg::ST_OSC;
        end
      end
      pwr_down_pkg::ST_OSC: begin
        // oscillator warm-up; the source keeps its level meanwhile
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          state_d = pwr_down_pkg::ST_HOLD;
        end
      end
      pwr_down_pkg::ST_HOLD: begin
        if (!waking_level) begin
          state_d = pwr_down_pkg::ST_RUN; // RULE6
        end
      end
      pwr_down_pkg::ST_RSTWIN: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1; // RULE13
        end else begin
          state_d = pwr_down_pkg::ST_RSTSEQ;
        end
      end
      pwr_down_pkg::ST_RSTSEQ: begin
        if (!rst_pin_q) begin
          state_d = pwr_down_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = pwr_down_pkg::ST_RUN;
      end
    endcase
    // reset pin after power-down opens a short execution window
    if (rst_pin_q && state_q != pwr_down_pkg::ST_RSTWIN &&
        state_q != pwr_down_pkg::ST_RSTSEQ) begin
      pd_bit_d = 1'b0;
      cnt_d = `RESET_TAKEOVER_CYC;
      state_d = (state_q == pwr_down_pkg::ST_DOWN) ?
                pwr_down_pkg::ST_RSTWIN : pwr_down_pkg::ST_RSTSEQ;
    end
  end

  // registers; reset pin also clears the request bit without a clock
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_q <= pwr_down_pkg::ST_RUN;
      cnt_q <= 4'h0;
      wake_src_q <= 1'b0;
      rst_pin_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wake_src_q <= wake_src_d;
      rst_pin_q <= rst_pin_d;
    end
  end

  // request bit kept apart so the reset pin reaches it unclocked
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I or posedge RST_PIN_I) begin
    if (!RSTN_I) begin
      pd_bit_q <= 1'b0;
    end else if (RST_PIN_I) begin
      pd_bit_q <= 1'b0; // RULE12
    end else begin
      pd_bit_q <= pd_bit_d;
    end
  end

  // clock and core controls, combinational from state
  always_comb begin
    // the bit gates the oscillator, so a reset restarts it at once
    OSC_EN_O = !pd_bit_q; // RULE20 RULE12
    CLK_GATE_EN_O = !pd_bit_q && state_q != pwr_down_pkg::ST_OSC; // RULE5
    // no instruction issues while down or waiting for release
    CORE_RUN_O = state_q == pwr_down_pkg::ST_RUN ||
                 state_q == pwr_down_pkg::ST_RSTWIN; // RULE2 RULE6 RULE13
    // ram and registers untouched across an interrupt wake
    RAM_ACCESS_EN_O = state_q == pwr_down_pkg::ST_RUN; // RULE3 RULE11 RULE15
    SFR_RESET_O = state_q == pwr_down_pkg::ST_RSTSEQ; // RULE17
    FETCH_LOAD_O = state_q == pwr_down_pkg::ST_RSTSEQ && !rst_pin_q; // RULE14
  end

  assign POWER_DOWN_REQUEST_BIT_O = pd_bit_q;
  assign FETCH_VECTOR_O = `RESET_VECTOR; // RULE14

  // pending service flag raised on return from an interrupt wake
  logic svc_q, svc_d;
  always_comb begin
    svc_d = svc_q;
    if (state_q == pwr_down_pkg::ST_HOLD && !waking_level) begin
      svc_d = 1'b1; // RULE7
    end else if (state_q == pwr_down_pkg::ST_RUN) begin
      svc_d = 1'b0;
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      svc_q <= 1'b0;
    end else begin
      svc_q <= svc_d;
    end
  end
  assign IRQ_SERVICE_O = svc_q; // RULE7

  // pin conditions per operating mode, registered
  logic p0_oe_n_q, p0_oe_n_d, hi_q, hi_d, strobe_q, strobe_d;
  always_comb begin
    hi_d = 1'b0;
    strobe_d = 1'b1;
    p0_oe_n_d = 1'b0;
    if (state_q == pwr_down_pkg::ST_RSTSEQ) begin
      hi_d = 1'b1; // RULE18
      p0_oe_n_d = 1'b1; // RULE18
    end else if (pd_bit_q) begin
      strobe_d = 1'b0; // RULE19
      p0_oe_n_d = EXT_CODE_I; // RULE19
    end else if (IDLE_I) begin
      p0_oe_n_d = EXT_CODE_I; // RULE18
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      p0_oe_n_q <= 1'b1;
      hi_q <= 1'b1;
      strobe_q <= 1'b1;
    end else begin
      p0_oe_n_q <= p0_oe_n_d;
      hi_q <= hi_d;
      strobe_q <= strobe_d;
    end
  end
  assign PORT0_OE_N_O = p0_oe_n_q;
  assign PORTS_FORCE_HIGH_O = hi_q;
  assign ALE_O = strobe_q;
  assign PROGRAM_STORE_STROBE_N_O = strobe_q;

  // entry: a request taken in run lands on the next edge
  // the reset pin is excluded, it clears the bit without a clock
  a_enter_down: assert property ( // RULE1
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    state_q == pwr_down_pkg::ST_RUN && PD_SET_I && !rst_pin_q && !RST_PIN_I
    |=> pd_bit_q && !CORE_RUN_O)
    else $error("power-down not entered");

  // halted core and closed ram for as long as the bit stands
  a_halt_down: assert property ( // RULE2
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    pd_bit_q |-> !CORE_RUN_O && !RAM_ACCESS_EN_O)
    else $error("core runs in power-down");

  // no oscillator and no gated clock while down
  a_clock_stop: assert property ( // RULE20
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    pd_bit_q |-> !OSC_EN_O && !CLK_GATE_EN_O)
    else $error("clock runs in power-down");

  // an enabled low level on line zero ends power-down
  a_irq_wake: assert property ( // RULE4
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    state_q == pwr_down_pkg::ST_DOWN && wake_zero && !rst_pin_q
    |=> !pd_bit_q && OSC_EN_O)
    else $error("interrupt wake missed");

  // line one alone wakes as well and is remembered as the source
  a_irq_one_wake: assert property ( // RULE4
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    state_q == pwr_down_pkg::ST_DOWN && wake_one && !wake_zero &&
    !rst_pin_q
    |=> !pd_bit_q && wake_src_q)
    else $error("line one wake missed");

  // gated clocks return once the warm-up count has run out
  a_clk_restore: assert property ( // RULE5
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    $fell(pd_bit_q) && state_q == pwr_down_pkg::ST_OSC
    |-> ##5 CLK_GATE_EN_O)
    else $error("clocks not restored");

  // the oscillator is always enabled once the bit is clear
  a_osc_resume: assert property ( // RULE5
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    !pd_bit_q |-> OSC_EN_O)
    else $error("oscillator left stopped");

  // no instruction while the waking line is still held
  a_hold_release: assert property ( // RULE6
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    state_q == pwr_down_pkg::ST_HOLD && waking_level |-> !CORE_RUN_O)
    else $error("core ran before release");

  // release leads to run with the service flag up
  a_svc_first: assert property ( // RULE7
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    state_q == pwr_down_pkg::ST_HOLD && !waking_level && !rst_pin_q
    |=> CORE_RUN_O && IRQ_SERVICE_O)
    else $error("service not flagged");

  // the service flag is a single-cycle pulse when release leads straight to run
  a_svc_pulse: assert property ( // RULE7
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    IRQ_SERVICE_O |=> !IRQ_SERVICE_O)
    else $error("service flag stuck");

  // ram stays closed all through the interrupt wake path
  a_ram_wake: assert property ( // RULE3
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    state_q == pwr_down_pkg::ST_OSC || state_q == pwr_down_pkg::ST_HOLD
    |-> !RAM_ACCESS_EN_O && !SFR_RESET_O)
    else $error("ram or registers touched on wake");

  // a high reset pin never leaves the request bit set
  a_rst_clear: assert property ( // RULE12
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    RST_PIN_I |-> !pd_bit_q)
    else $error("reset pin left request set");

  // the window after a reset wake lasts nine cycles
  a_window_len: assert property ( // RULE13
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    state_q == pwr_down_pkg::ST_RSTWIN &&
    $past(state_q) == pwr_down_pkg::ST_DOWN
    |-> ##9 state_q == pwr_down_pkg::ST_RSTSEQ)
    else $error("reset window length wrong");

  // strobes low once the bit has stood for two samples
  // a single sample still sees the strobes registered before the bit rose
  a_pd_pins: assert property ( // RULE19
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    pd_bit_q ##1 pd_bit_q
    |-> !ALE_O && !PROGRAM_STORE_STROBE_N_O)
    else $error("strobes not low in power-down");

  // core may run in the window, but ram stays blocked
  a_rst_window: assert property ( // RULE15
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    state_q == pwr_down_pkg::ST_RSTWIN |-> CORE_RUN_O && !RAM_ACCESS_EN_O)
    else $error("ram open in reset window");

  // reset sequence: registers reset, ports high, port 0 floats
  a_rst_pins: assert property ( // RULE18
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    state_q == pwr_down_pkg::ST_RSTSEQ
    |=> PORTS_FORCE_HIGH_O && PORT0_OE_N_O && ALE_O)
    else $error("pins wrong in reset");

  // registers reset during the sequence, ram left closed
  a_sfr_reset: assert property ( // RULE17
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    state_q == pwr_down_pkg::ST_RSTSEQ |-> SFR_RESET_O && !RAM_ACCESS_EN_O)
    else $error("registers not reset");

  // fetch restarts at the reset vector once the pin falls
  a_fetch_load: assert property ( // RULE14
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    FETCH_LOAD_O |=> state_q == pwr_down_pkg::ST_RUN && !SFR_RESET_O)
    else $error("fetch load misplaced");

endmodule

/* sim/core_irq_src.sv */
// stands in for the core and the wake sources outside the block
module core_irq_src (
  input wire logic clk_i,
  output logic pd_set_o,
  output logic irq_zero_n_o,
  output logic irq_one_n_o,
  output logic irq_zero_en_o,
  output logic irq_one_en_o,
  output logic rst_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle levels: no request, lines released, nothing enabled
  initial begin
    pd_set_o = 1'b0;
    irq_zero_n_o = 1'b1;
    irq_one_n_o = 1'b1;
    irq_zero_en_o = 1'b0;
    irq_one_en_o = 1'b0;
    rst_pin_o = 1'b0;
  end
  // one write, then a slot that touches no port
  task automatic request_down();
    @(posedge clk_i);
    pd_set_o <= 1'b1;
    @(posedge clk_i);
    pd_set_o <= 1'b0;
  endtask
  // a level, not an edge, so the wake holds until released
  task automatic drive_irq(input logic which, input logic lvl_n);
    @(posedge clk_i);
    if (which) irq_one_n_o <= lvl_n;
    else irq_zero_n_o <= lvl_n;
  endtask
  // only the waking source enabled, so nothing outranks it
  task automatic set_en(input logic en0, input logic en1);
    @(posedge clk_i);
    irq_zero_en_o <= en0;
    irq_one_en_o <= en1;
  endtask
  task automatic set_rst(input logic lvl);
    @(posedge clk_i);
    rst_pin_o <= lvl;
  endtask
endmodule

/* sim/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, idle, ext_code, pd_set, irq0_n, irq1_n, en0, en1;
  logic rst_pin, pd_bit, osc_en, gate_en, core_run, irq_svc, ram_en;
  logic sfr_rst, fetch_ld, p0_oe_n, force_hi, ale, store_n;
  logic [15:0] vec;
  int n_fail = 0;
  int checked = 0;
  int k;
  core_irq_src src (.clk_i(clk), .pd_set_o(pd_set),
    .irq_zero_n_o(irq0_n), .irq_one_n_o(irq1_n), .irq_zero_en_o(en0),
    .irq_one_en_o(en1), .rst_pin_o(rst_pin));
  power_down_mode_control DUT (.CLK_SYS_I(clk), .RSTN_I(rstn),
    .RST_PIN_I(rst_pin), .PD_SET_I(pd_set), .IDLE_I(idle),
    .EXT_CODE_I(ext_code), .EXT_IRQ_ZERO_N_I(irq0_n),
    .EXT_IRQ_ONE_N_I(irq1_n), .IRQ_ZERO_EN_I(en0), .IRQ_ONE_EN_I(en1),
    .POWER_DOWN_REQUEST_BIT_O(pd_bit), .OSC_EN_O(osc_en),
    .CLK_GATE_EN_O(gate_en), .CORE_RUN_O(core_run),
    .IRQ_SERVICE_O(irq_svc), .RAM_ACCESS_EN_O(ram_en),
    .SFR_RESET_O(sfr_rst), .FETCH_VECTOR_O(vec), .FETCH_LOAD_O(fetch_ld),
    .PORT0_OE_N_O(p0_oe_n), .PORTS_FORCE_HIGH_O(force_hi), .ALE_O(ale),
    .PROGRAM_STORE_STROBE_N_O(store_n));
  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic close_out();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // sample just past the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_idle();
    @(posedge clk);
    idle <= 1'b1;
    ext_code <= 1'b1;
    tick(2);
    chk_bit(ale, 1'b1);
    chk_bit(store_n, 1'b1);
    chk_bit(p0_oe_n, 1'b1);
    @(posedge clk);
    ext_code <= 1'b0;
    tick(2);
    chk_bit(p0_oe_n, 1'b0);
    @(posedge clk);
    idle <= 1'b0;
  endtask
  // wake through one interrupt line; the other stays idle
  task automatic t_irq_wake(input logic which, input logic ext);
    @(posedge clk);
    ext_code <= ext;
    src.request_down();
    tick(1);
    chk_bit(pd_bit, 1'b1);
    chk_bit(core_run, 1'b0);
    chk_bit(osc_en, 1'b0);
    chk_bit(gate_en, 1'b0);
    chk_bit(ale, 1'b0);
    chk_bit(store_n, 1'b0);
    chk_bit(ram_en, 1'b0);
    chk_bit(p0_oe_n, ext);
    src.drive_irq(which, 1'b0);
    tick(3);
    chk_bit(pd_bit, 1'b1);
    src.set_en(~which, which);
    tick(2);
    chk_bit(pd_bit, 1'b0);
    chk_bit(osc_en, 1'b1);
    chk_bit(gate_en, 1'b0);
    tick(8);
    chk_bit(gate_en, 1'b1);
    chk_bit(core_run, 1'b0);
    src.drive_irq(which, 1'b1);
    for (k = 0; k < 6 && core_run !== 1'b1; k++) tick(1);
    chk_bit(core_run, 1'b1);
    chk_bit(irq_svc, 1'b1);
    chk_bit(ram_en, 1'b1);
    tick(1);
    chk_bit(irq_svc, 1'b0);
    chk_bit(sfr_rst, 1'b0);
    src.set_en(1'b0, 1'b0);
  endtask
  task automatic t_rst_wake();
    src.request_down();
    tick(2);
    chk_bit(p0_oe_n, 1'b0);
    src.set_rst(1'b1);
    #1;
    chk_bit(pd_bit, 1'b0);
    for (k = 0; k < 6 && core_run !== 1'b1; k++) tick(1);
    chk_bit(core_run, 1'b1);
    chk_bit(ram_en, 1'b0);
    for (k = 0; k < 20 && sfr_rst !== 1'b1; k++) tick(1);
    tick(1);
    chk_bit(sfr_rst, 1'b1);
    chk_bit(force_hi, 1'b1);
    chk_bit(p0_oe_n, 1'b1);
    chk_bit(ale, 1'b1);
    src.set_rst(1'b0);
    for (k = 0; k < 10 && fetch_ld !== 1'b1; k++) tick(1);
    chk_bit(fetch_ld, 1'b1);
    chk_vec(vec, 16'h0000);
  endtask
  initial begin
    rstn = 1'b0;
    idle = 1'b0;
    ext_code = 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    tick(2);
    t_idle();
    t_irq_wake(1'b0, 1'b1);
    t_irq_wake(1'b1, 1'b0);
    t_rst_wake();
    close_out();
  end
  // the whole run needs under a hundred cycles
  initial begin
    #(40 * 3000);
    n_fail++;
    close_out();
  end
endmodule
